// ===== common/csw_pkg.sv
// constants and carrier types for the comparator shot/window control block
// assumes a 32-bit classic wishbone bus with byte addresses on 8 bits
package csw_pkg;
   // ==========================================================
   // sizes
   localparam int unsigned NCMP     = 2;
   localparam int unsigned AW       = 8;
   localparam int unsigned SCALER_W = 6;   // 64 supply levels
   // ==========================================================
   // register byte offsets
   localparam logic [7:0] OFS_CTRL0   = 8'h00;
   localparam logic [7:0] OFS_CTRL1   = 8'h04;
   localparam logic [7:0] OFS_START   = 8'h08;
   localparam logic [7:0] OFS_EVCTL   = 8'h0C;
   localparam logic [7:0] OFS_WINCTL  = 8'h10;
   localparam logic [7:0] OFS_STAT1   = 8'h14;
   localparam logic [7:0] OFS_STAT2   = 8'h18;
   localparam logic [7:0] OFS_SCALER0 = 8'h1C;
   localparam logic [7:0] OFS_SCALER1 = 8'h20;
   // ==========================================================
   // field positions
   localparam int unsigned BIT_TRIG_EN = 0;  // event_control [1:0]
   localparam int unsigned BIT_CMP_EO  = 4;  // event_control [5:4]
   localparam int unsigned BIT_WIN_EO  = 6;  // event_control [6]
   localparam int unsigned BIT_WSTATE  = 4;  // status_first [5:4]
   // ==========================================================
   // codes and reset values
   localparam logic [2:0]  NEG_SCALER  = 3'h5;
   localparam logic [2:0]  POS_SCALER  = 3'h4;
   localparam logic [1:0]  IRQ_TOGGLE  = 2'h0;
   localparam logic [1:0]  IRQ_RISE    = 2'h1;
   localparam logic [1:0]  IRQ_FALL    = 2'h2;
   localparam logic [1:0]  IRQ_EOC     = 2'h3;
   localparam logic [1:0]  WIN_ABOVE   = 2'h0;
   localparam logic [1:0]  WIN_INSIDE  = 2'h1;
   localparam logic [1:0]  WIN_BELOW   = 2'h2;
   localparam logic [1:0]  WIN_OUTSIDE = 2'h3;  // interrupt select only
   localparam logic [31:0] RST_WORD    = 32'h0000_0000;
   // ==========================================================
   // comparator_control layout, bit 0 upward from the right
   typedef struct packed {
      logic [17:0] rsvd_hi;
      logic [2:0]  neg_sel;
      logic        rsvd_lo;
      logic [2:0]  pos_sel;
      logic [1:0]  irq_sel;
      logic [1:0]  speed;
      logic        hyst;
      logic        single;
      logic        enable;
   } csw_cctl_s;
   // window_control layout
   typedef struct packed {
      logic [28:0] rsvd;
      logic [1:0]  irq_sel;
      logic        enable;
   } csw_wctl_s;
   typedef enum logic [1:0] {CS_OFF, CS_WARM, CS_RUN} csw_cstate_e;
endpackage : csw_pkg

// ===== src/csw_ctrl.sv
// control logic for a pair of analog comparators with single-shot and window modes
// assumes comparator outputs and start-up done flags arrive synchronous to sys_clk
//
// Function
// - single bit set: idle until started
// - start enables, one compare, update, events
// - start clears ready; finish sets ready
// - enabled trigger event starts like software
// - outside window, own event only
// - edge uses previous measurement result
// - sleep trigger requests clock, then releases it
// - pos select pins, neg select pins/references
// - window enable pairs comparators into range
// - window state readable in status_first
// - window irq: below, above, enter, leave
// - window event follows inside state
// - comparators keep own outputs in window
// - window single-shot: either start starts both
// - scaler on when enabled and selected
// - hysteresis only in continuous mode
// - speed field selects bias current
// - single clear: continuous, state always fresh
// - output ignored until start-up done
// - window irq select is two bits
//
// Chosen here: the Wishbone interface to the registers and the register offsets.
module csw_ctrl
   import csw_pkg::*;
(
   input  wire logic                     sys_clk,
   input  wire logic                     reset_n,
   input  wire logic                     wb_cyc,
   input  wire logic                     wb_stb,
   input  wire logic                     wb_we,
   input  wire logic [AW-1:0]            wb_adr,
   input  wire logic [3:0]               wb_sel,
   input  wire logic [31:0]              wb_dat_w,
   output logic      [31:0]              wb_dat_r,
   output logic                          wb_ack,
   input  wire logic [NCMP-1:0]          cmp_out,
   input  wire logic [NCMP-1:0]          startup_done,
   input  wire logic [NCMP-1:0]          evt_start,
   input  wire logic                     sleep_mode,
   input  wire logic                     wake_enable,
   output logic      [NCMP-1:0]          cmp_enable,
   output logic      [NCMP-1:0][2:0]     pos_sel,
   output logic      [NCMP-1:0][2:0]     neg_sel,
   output logic      [NCMP-1:0][1:0]     speed_sel,
   output logic      [NCMP-1:0]          hyst_on,
   output logic      [NCMP-1:0]          scaler_en,
   output logic      [NCMP-1:0][SCALER_W-1:0] scaler_val,
   output logic      [NCMP-1:0]          evt_cmp,
   output logic                          evt_win,
   output logic      [NCMP-1:0]          cmp_irq,
   output logic                          win_irq,
   output logic                          clk_req,
   output logic                          wake_req
);
   // ==========================================================
   // registers
   csw_cctl_s                     cctl_reg [NCMP];
   csw_wctl_s                     wctl_reg;
   logic [6:0]                    evctl_reg;
   logic [NCMP-1:0][SCALER_W-1:0] scaler_reg;
   csw_cstate_e                   cst_reg [NCMP];
   csw_cstate_e                   cst_next [NCMP];
   logic [NCMP-1:0]               state_reg;
   logic [NCMP-1:0]               ready_reg;
   logic [1:0]                    wstate_reg;

   // merge a written word into a register under the byte enables
   function automatic logic [31:0] csw_merge(input logic [31:0] old_w, input logic [31:0] new_w,
                                             input logic [3:0] sel);
      logic [31:0] res;
      res = old_w;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            res[8*b +: 8] = new_w[8*b +: 8];
         end
      end
      return res;
   endfunction : csw_merge

   // ==========================================================
   // bus decode: ack one cycle after the request, write lands at the acked edge
   wire logic acc       = wb_cyc & wb_stb;
   wire logic wr_fire   = acc & wb_we & wb_ack;
   wire logic hit_ctrl0 = (wb_adr == OFS_CTRL0);
   wire logic hit_ctrl1 = (wb_adr == OFS_CTRL1);
   wire logic hit_start = (wb_adr == OFS_START);
   wire logic hit_evctl = (wb_adr == OFS_EVCTL);
   wire logic hit_wctl  = (wb_adr == OFS_WINCTL);
   wire logic hit_stat1 = (wb_adr == OFS_STAT1);
   wire logic hit_stat2 = (wb_adr == OFS_STAT2);
   wire logic hit_scl0  = (wb_adr == OFS_SCALER0);
   wire logic hit_scl1  = (wb_adr == OFS_SCALER1);

   // read mux; the start register is write-only and reads as zero, as do holes
   wire logic [31:0] stat1_word = 32'({wstate_reg, 2'b00, state_reg});
   wire logic [31:0] rd_word =
      hit_ctrl0 ? 32'(cctl_reg[0]) :
      hit_ctrl1 ? 32'(cctl_reg[1]) :
      hit_evctl ? 32'(evctl_reg) :
      hit_wctl  ? 32'(wctl_reg) :
      hit_stat1 ? stat1_word :
      hit_stat2 ? 32'(ready_reg) :
      hit_scl0  ? 32'(scaler_reg[0]) :
      hit_scl1  ? 32'(scaler_reg[1]) : RST_WORD;

   wire logic [31:0] wr_ctrl0 = csw_merge(32'(cctl_reg[0]), wb_dat_w, wb_sel);
   wire logic [31:0] wr_ctrl1 = csw_merge(32'(cctl_reg[1]), wb_dat_w, wb_sel);
   wire logic [31:0] wr_evctl = csw_merge(32'(evctl_reg), wb_dat_w, wb_sel);
   wire logic [31:0] wr_wctl  = csw_merge(32'(wctl_reg), wb_dat_w, wb_sel);
   wire logic [31:0] wr_scl0  = csw_merge(32'(scaler_reg[0]), wb_dat_w, wb_sel);
   wire logic [31:0] wr_scl1  = csw_merge(32'(scaler_reg[1]), wb_dat_w, wb_sel);

   // ==========================================================
   // start requests; a zero written to a start bit does nothing
   wire logic [NCMP-1:0] sw_start = (wr_fire & hit_start & wb_sel[0]) ? wb_dat_w[NCMP-1:0]
                                                                         : '0;
   wire logic [NCMP-1:0] req      = sw_start | (evt_start & evctl_reg[BIT_TRIG_EN +: NCMP]);
   wire logic            win_shot = wctl_reg.enable & cctl_reg[0].single & cctl_reg[1].single;
   // in window single-shot either request starts both, else each its own
   wire logic [NCMP-1:0] go       = win_shot ? {NCMP{|req}} : req;

   logic [NCMP-1:0] accept;
   logic [NCMP-1:0] sample;
   logic [NCMP-1:0] changed;
   logic [NCMP-1:0] irq_cond;
   logic [NCMP-1:0] state_next;
   logic [NCMP-1:0] active_next;
   logic [NCMP-1:0] scl_sel;

   // ==========================================================
   // per comparator sequencing
   for (genvar i = 0; i < NCMP; i++) begin : g_cmp
      // a shot is taken only from idle, so a start during a running shot is dropped
      assign accept[i] = go[i] & cctl_reg[i].enable & cctl_reg[i].single
                         & (cst_reg[i] == CS_OFF);
      // nothing is sampled before the measured start-up time has passed
      assign sample[i] = ((cst_reg[i] == CS_WARM) & startup_done[i])
                         | (cst_reg[i] == CS_RUN);
      assign cst_next[i] = !cctl_reg[i].enable ? CS_OFF :
                           (cst_reg[i] == CS_OFF) ?
                              ((accept[i] | !cctl_reg[i].single) ? CS_WARM : CS_OFF) :
                           ((cst_reg[i] == CS_WARM) & startup_done[i]) ?
                              (cctl_reg[i].single ? CS_OFF : CS_RUN) :
                           cst_reg[i];
      assign state_next[i]  = sample[i] ? cmp_out[i] : state_reg[i];
      // edge taken against the previous result, one sampling period back
      assign changed[i]     = sample[i] & (cmp_out[i] ^ state_reg[i]);
      assign irq_cond[i]    = (cctl_reg[i].irq_sel == IRQ_TOGGLE) ? changed[i] :
                              (cctl_reg[i].irq_sel == IRQ_RISE)   ? changed[i] & cmp_out[i] :
                              (cctl_reg[i].irq_sel == IRQ_FALL)   ? changed[i] & ~cmp_out[i] :
                              sample[i];
      assign active_next[i] = (cst_next[i] != CS_OFF);
      assign scl_sel[i]     = (cctl_reg[i].neg_sel == NEG_SCALER)
                              | (cctl_reg[i].pos_sel == POS_SCALER);

      // assertions for this comparator
      start_clears_ready_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
         accept[i] |=> !ready_reg[i]) else $error("start did not clear ready");
      shot_sets_ready_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
         sample[i] |=> ready_reg[i]) else $error("ready not set after compare");
      single_one_shot_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
         (cst_reg[i] == CS_WARM && startup_done[i] && cctl_reg[i].single && cctl_reg[i].enable)
         |=> cst_reg[i] == CS_OFF ##1 cst_reg[i] == CS_OFF || $past(accept[i]))
         else $error("single shot did more than one compare");
      result_latch_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
         sample[i] |=> state_reg[i] == $past(cmp_out[i])) else $error("result not stored");
      startup_hold_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
         (cst_reg[i] != CS_RUN && !(cst_reg[i] == CS_WARM && startup_done[i]))
         |=> $stable(state_reg[i])) else $error("state changed before start-up");
      busy_ignore_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
         (cst_reg[i] == CS_WARM && !startup_done[i] && cctl_reg[i].enable && cctl_reg[i].single && go[i])
         |=> !ready_reg[i] && cst_reg[i] == CS_WARM) else $error("start taken while busy");
      scaler_gate_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
         !cctl_reg[i].enable |=> !scaler_en[i] && !cmp_enable[i]) else $error("scaler on");
      hyst_cont_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
         cctl_reg[i].single |=> !hyst_on[i]) else $error("hysteresis in single-shot");
   end : g_cmp

   // ==========================================================
   // window evaluation: inside when the two results differ, either limit order works
   wire logic [1:0] wstate_next = (state_next[0] ^ state_next[1]) ? WIN_INSIDE :
                                  state_next[0] ? WIN_ABOVE : WIN_BELOW;
   wire logic       wchg        = wctl_reg.enable & (wstate_next != wstate_reg);
   wire logic       win_cond    =
      (wctl_reg.irq_sel == WIN_ABOVE)  ? wchg & (wstate_next == WIN_ABOVE) :
      (wctl_reg.irq_sel == WIN_INSIDE) ? wchg & (wstate_next == WIN_INSIDE) :
      (wctl_reg.irq_sel == WIN_BELOW)  ? wchg & (wstate_next == WIN_BELOW) :
      wchg & (wstate_reg == WIN_INSIDE);

   // ==========================================================
   // bus answer
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         wb_ack   <= 1'b0;
         wb_dat_r <= RST_WORD;
      end else begin
         wb_ack   <= acc & ~wb_ack;
         wb_dat_r <= (acc & ~wb_ack) ? rd_word : wb_dat_r;
      end
   end

   // software registers; selects are written whenever addressed, whether the comparator is on or off
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         cctl_reg   <= '{default: '0};
         wctl_reg   <= '0;
         evctl_reg  <= '0;
         scaler_reg <= '0;
      end else if (wr_fire) begin
         if (hit_ctrl0) cctl_reg[0]   <= csw_cctl_s'(wr_ctrl0);
         if (hit_ctrl1) cctl_reg[1]   <= csw_cctl_s'(wr_ctrl1);
         if (hit_evctl) evctl_reg     <= wr_evctl[6:0];
         if (hit_wctl)  wctl_reg      <= csw_wctl_s'({29'h0, wr_wctl[2:0]});
         if (hit_scl0)  scaler_reg[0] <= wr_scl0[SCALER_W-1:0];
         if (hit_scl1)  scaler_reg[1] <= wr_scl1[SCALER_W-1:0];
      end
   end

   // ==========================================================
   // comparator state, ready flags and analog controls
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         cst_reg    <= '{default: CS_OFF};
         state_reg  <= '0;
         ready_reg  <= '0;
         cmp_enable <= '0;
         hyst_on    <= '0;
         scaler_en  <= '0;
         pos_sel    <= '0;
         neg_sel    <= '0;
         speed_sel  <= '0;
         scaler_val <= '0;
         evt_cmp    <= '0;
         cmp_irq    <= '0;
      end else begin
         for (int i = 0; i < NCMP; i++) begin
            cst_reg[i]    <= cst_next[i];
            // set from a finished compare, cleared by an accepted start
            ready_reg[i]  <= sample[i] | (ready_reg[i] & ~accept[i]);
            hyst_on[i]    <= cctl_reg[i].enable & cctl_reg[i].hyst & ~cctl_reg[i].single;
            pos_sel[i]    <= cctl_reg[i].pos_sel;
            neg_sel[i]    <= cctl_reg[i].neg_sel;
            speed_sel[i]  <= cctl_reg[i].speed;
            scaler_val[i] <= scaler_reg[i];
            evt_cmp[i]    <= state_next[i] & evctl_reg[BIT_CMP_EO + i];
         end
         state_reg  <= state_next;
         cmp_enable <= active_next;
         scaler_en  <= active_next & scl_sel;
         cmp_irq    <= irq_cond;
      end
   end

   // ==========================================================
   // window state, window event and clock request toward the power manager
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         wstate_reg <= WIN_BELOW;
         evt_win    <= 1'b0;
         win_irq    <= 1'b0;
         clk_req    <= 1'b0;
         wake_req   <= 1'b0;
      end else begin
         wstate_reg <= wctl_reg.enable ? wstate_next : wstate_reg;
         // follows the inside state with or without the interrupt selected
         evt_win    <= wctl_reg.enable & evctl_reg[BIT_WIN_EO]
                       & (wstate_next == WIN_INSIDE);
         win_irq    <= win_cond;
         // clock held only while a comparator runs; dropped after a lone shot
         clk_req    <= |active_next;
         wake_req   <= sleep_mode & wake_enable & (|irq_cond | win_cond);
      end
   end

   // ==========================================================
   // pair-level checks
   win_both_start_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
      (win_shot && |req && accept[0] && cctl_reg[1].enable && cst_reg[1] == CS_OFF)
      |=> cst_reg[0] != CS_OFF && cst_reg[1] != CS_OFF) else $error("window pair not started");
   win_event_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
      ($past(wctl_reg.enable && evctl_reg[BIT_WIN_EO]) && wstate_reg == WIN_INSIDE) |-> evt_win)
      else $error("window event lost");
   start_reads_zero_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
      (wb_ack && hit_start && !wb_we) |-> wb_dat_r == RST_WORD) else $error("start read nonzero");
endmodule : csw_ctrl

// ===== verif/csw_analog_model.sv
// behavioural model of the two analog comparator cores
// assumes cmp_enable from the control block; the bench sets the analog levels
module csw_analog_model
   import csw_pkg::*;
(
   input  wire logic            sys_clk,
   input  wire logic            reset_n,
   input  wire logic [NCMP-1:0] cmp_enable,
   input  wire logic [NCMP-1:0] level,
   input  wire logic            slow,
   output logic      [NCMP-1:0] startup_done,
   output logic      [NCMP-1:0] cmp_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [4:0] warm_cnt [NCMP];
   // ==========================================================
   // start-up timer, restarts whenever a core is switched off
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         for (int i = 0; i < NCMP; i++) begin
            warm_cnt[i] <= 5'h00;
         end
      end else begin
         for (int i = 0; i < NCMP; i++) begin
            if (!cmp_enable[i]) begin
               warm_cnt[i] <= 5'h00;
            end else if (warm_cnt[i] != 5'h1F) begin
               warm_cnt[i] <= warm_cnt[i] + 5'h01;
            end
         end
      end
   end
   // ==========================================================
   // output is junk (inverted level) until warm, so early sampling shows up
   always_comb begin
      for (int i = 0; i < NCMP; i++) begin
         startup_done[i] = cmp_enable[i] && (warm_cnt[i] >= (slow ? 5'h0C : 5'h03));
         cmp_out[i]      = startup_done[i] ? level[i] : ~level[i];
      end
   end
endmodule : csw_analog_model

// ===== verif/csw_ctrl_test.sv
// self-checking bench for the comparator shot/window control block
// assumes the analog model stands on the far side; registers reached over wishbone
module csw_ctrl_test
   import csw_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk, reset_n, wb_cyc, wb_stb, wb_we, wb_ack, sleep_mode, wake_enable, slow, evt_win, win_irq;
   logic clk_req, wake_req;
   logic [AW-1:0] wb_adr;
   logic [3:0] wb_sel;
   logic [31:0] wb_dat_w, wb_dat_r, rd;
   logic [NCMP-1:0] cmp_out, startup_done, evt_start, cmp_enable, level, hyst_on, scaler_en, evt_cmp, cmp_irq;
   logic [NCMP-1:0][2:0] pos_sel, neg_sel;
   logic [NCMP-1:0][1:0] speed_sel;
   logic [NCMP-1:0][SCALER_W-1:0] scaler_val;
   int failures = 0, comparisons = 0, cycles = 0, irq0_cnt = 0, win_cnt = 0, wake_cnt = 0;
   csw_ctrl csw_ctrl_inst (.sys_clk(sys_clk), .reset_n(reset_n), .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we),
      .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r), .wb_ack(wb_ack),
      .cmp_out(cmp_out), .startup_done(startup_done), .evt_start(evt_start), .sleep_mode(sleep_mode),
      .wake_enable(wake_enable), .cmp_enable(cmp_enable), .pos_sel(pos_sel), .neg_sel(neg_sel),
      .speed_sel(speed_sel), .hyst_on(hyst_on), .scaler_en(scaler_en), .scaler_val(scaler_val),
      .evt_cmp(evt_cmp), .evt_win(evt_win), .cmp_irq(cmp_irq), .win_irq(win_irq), .clk_req(clk_req),
      .wake_req(wake_req));
   csw_analog_model csw_analog_model_inst (.sys_clk(sys_clk), .reset_n(reset_n), .cmp_enable(cmp_enable),
      .level(level), .slow(slow), .startup_done(startup_done), .cmp_out(cmp_out));
   // ==========================================================
   // clock, interrupt pulse counters and hang guard
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      cycles++;
      if (cmp_irq[0] === 1'b1) irq0_cnt++;
      if (win_irq === 1'b1) win_cnt++;
      if (wake_req === 1'b1) wake_cnt++;
      if (cycles == 20000) begin
         failures++;
         give_verdict();
      end
   end
   task automatic give_verdict();
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : give_verdict
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   // ==========================================================
   // classic wishbone cycle: hold everything until ack is sampled high
   task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat);
      @(posedge sys_clk);
      wb_cyc <= 1'b1; wb_stb <= 1'b1; wb_we <= we; wb_adr <= adr; wb_dat_w <= dat; wb_sel <= 4'hF;
      // no local limit: only the bench's cycle ceiling ends a hung wait
      do begin
         @(posedge sys_clk);
      end while (wb_ack !== 1'b1);
      rd = wb_dat_r;
      wb_cyc <= 1'b0; wb_stb <= 1'b0; wb_we <= 1'b0;
   endtask : wb_xfer
   task automatic wait_ready(input logic [1:0] mask);
      do begin
         wb_xfer(1'b0, OFS_STAT2, 32'h0000_0000);
      end while ((rd[1:0] & mask) !== mask);
   endtask : wait_ready
   task automatic pulse_evt(input logic [1:0] which);
      @(posedge sys_clk);
      evt_start <= which;
      @(posedge sys_clk);
      evt_start <= 2'h0;
   endtask : pulse_evt
   // ==========================================================
   // scenarios
   task automatic t_reset_map();
      wb_xfer(1'b0, OFS_STAT1, 32'h0000_0000);
      chk("wstate_reset", {30'h0, WIN_BELOW}, {30'h0, rd[5:4]});
      wb_xfer(1'b1, OFS_START, 32'h0000_0000);
      wb_xfer(1'b0, OFS_START, 32'h0000_0000);
      chk("start_read", RST_WORD, rd);
      wb_xfer(1'b0, 8'h3C, 32'h0000_0000);
      chk("unmapped_read", RST_WORD, rd);
   endtask : t_reset_map
   task automatic t_soft_shot();
      int base;
      slow <= 1'b1; level <= 2'h1;
      wb_xfer(1'b1, OFS_CTRL0, 32'h0000_0063);
      repeat (5) @(posedge sys_clk);
      chk("idle_single", 32'h0, {31'h0, cmp_enable[0]});
      base = irq0_cnt;
      wb_xfer(1'b1, OFS_START, 32'h0000_0001);
      wb_xfer(1'b0, OFS_STAT2, 32'h0000_0000);
      chk("ready_cleared", 32'h0, {31'h0, rd[0]});
      chk("enabled", 32'h1, {31'h0, cmp_enable[0]});
      chk("clk_request", 32'h1, {31'h0, clk_req});
      wb_xfer(1'b1, OFS_START, 32'h0000_0001);  // busy, must be ignored
      wait_ready(2'h1);
      repeat (20) @(posedge sys_clk);
      chk("one_irq", 32'h1, irq0_cnt - base);
      chk("disabled_after", 32'h0, {31'h0, cmp_enable[0]});
      wb_xfer(1'b0, OFS_STAT1, 32'h0000_0000);
      chk("state0", 32'h1, {31'h0, rd[0]});
      wb_xfer(1'b1, OFS_START, 32'h0000_0000);
      wb_xfer(1'b0, OFS_STAT2, 32'h0000_0000);
      chk("zero_start", 32'h1, {31'h0, rd[0]});
   endtask : t_soft_shot
   task automatic t_event_shot();
      int base;
      slow <= 1'b0; level <= 2'h2; base = wake_cnt;
      wb_xfer(1'b1, OFS_CTRL1, 32'h0000_0063);
      wb_xfer(1'b1, OFS_EVCTL, 32'h0000_0002);
      pulse_evt(2'h1);
      repeat (3) @(posedge sys_clk);
      chk("no_start_unenabled", 32'h0, {30'h0, cmp_enable});
      // asleep with wake allowed: the end-of-compare condition must raise one wake request
      sleep_mode <= 1'b1; wake_enable <= 1'b1;
      pulse_evt(2'h2);
      wait_ready(2'h2);
      wb_xfer(1'b0, OFS_STAT1, 32'h0000_0000);
      chk("state1_event", 32'h3, {30'h0, rd[1:0]});
      chk("wake_pulse", 32'h1, wake_cnt - base);
      chk("clk_released", 32'h0, {31'h0, clk_req});
      sleep_mode <= 1'b0; wake_enable <= 1'b0;
   endtask : t_event_shot
   task automatic t_window();
      int base;
      level <= 2'h1; base = win_cnt;
      wb_xfer(1'b1, OFS_CTRL0, 32'h0000_08E3);
      wb_xfer(1'b1, OFS_CTRL1, 32'h0000_10E3);
      wb_xfer(1'b1, OFS_EVCTL, 32'h0000_0071);
      wb_xfer(1'b1, OFS_WINCTL, 32'h0000_0003);
      wb_xfer(1'b1, OFS_START, 32'h0000_0002);
      wait_ready(2'h3);
      wb_xfer(1'b0, OFS_STAT1, 32'h0000_0000);
      chk("both_measured", 32'h1, {30'h0, rd[1:0]});
      chk("wstate_inside", {30'h0, WIN_INSIDE}, {30'h0, rd[5:4]});
      chk("win_evt", 32'h1, {31'h0, evt_win});
      chk("win_irq", 32'h1, win_cnt - base);
      chk("cmp_evt", 32'h1, {30'h0, evt_cmp});
      chk("pos_sel", 32'h1, {29'h0, pos_sel[1]});
      chk("neg_sel", 32'h2, {29'h0, neg_sel[1]});
      level <= 2'h0;
      pulse_evt(2'h1);
      wait_ready(2'h3);
      wb_xfer(1'b0, OFS_STAT1, 32'h0000_0000);
      chk("wstate_below", {30'h0, WIN_BELOW}, {30'h0, rd[5:4]});
      chk("win_evt_out", 32'h0, {31'h0, evt_win});
      wb_xfer(1'b1, OFS_WINCTL, 32'h0000_0000);
   endtask : t_window
   task automatic t_scaler_hyst();
      level <= 2'h1;
      wb_xfer(1'b1, OFS_SCALER0, 32'h0000_003F);
      wb_xfer(1'b1, OFS_CTRL0, 32'h0000_2815);
      repeat (20) @(posedge sys_clk);
      chk("hyst_cont", 32'h1, {31'h0, hyst_on[0]});
      chk("scaler_on", 32'h1, {31'h0, scaler_en[0]});
      chk("scaler_val", 32'h3F, {26'h0, scaler_val[0]});
      chk("speed", 32'h2, {30'h0, speed_sel[0]});
      level <= 2'h0;
      repeat (5) @(posedge sys_clk);
      wb_xfer(1'b0, OFS_STAT1, 32'h0000_0000);
      chk("cont_state", 32'h0, {31'h0, rd[0]});
      wb_xfer(1'b1, OFS_CTRL0, 32'h0000_2817);
      repeat (3) @(posedge sys_clk);
      chk("hyst_single", 32'h0, {31'h0, hyst_on[0]});
   endtask : t_scaler_hyst
   // ==========================================================
   // main sequence
   initial begin
      reset_n = 1'b0; wb_cyc = 1'b0; wb_stb = 1'b0; wb_we = 1'b0; wb_adr = 8'h00; wb_sel = 4'h0;
      wb_dat_w = 32'h0000_0000; evt_start = 2'h0; sleep_mode = 1'b0; wake_enable = 1'b0;
      slow = 1'b0; level = 2'h0;
      repeat (5) @(posedge sys_clk);
      reset_n <= 1'b1;
      t_reset_map();
      t_soft_shot();
      t_event_shot();
      t_window();
      t_scaler_hyst();
      give_verdict();
   end
endmodule : csw_ctrl_test
